// [hdl/ips_pkg.sv]
/*
 * package for the interrupt priority select block: register offsets,
 * field positions, reset values and bus encodings.
 * assumes an ahb-lite bus with 32-bit data and word-aligned registers.
 */
package ips_pkg;

    // ==========================================================
    // bus encodings
    localparam logic [1:0] IPS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] IPS_HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] IPS_HSIZE_WORD    = 3'h2;
    localparam logic       IPS_HRESP_OKAY    = 1'h0;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] IPS_PRIO_OFFSET   = 8'h00;
    localparam logic [7:0] IPS_STATUS_OFFSET = 8'h04;

    // ==========================================================
    // priority register fields
    localparam int         IPS_PRIO_WIDTH     = 8;
    localparam int         IPS_BIT_CLK_VALID  = 7;
    localparam int         IPS_BIT_RESERVED   = 6;
    localparam int         IPS_BIT_EXT7       = 5;
    localparam int         IPS_BIT_EXT6       = 4;
    localparam int         IPS_BIT_EXT5       = 3;
    localparam int         IPS_BIT_EXT4       = 2;
    localparam int         IPS_BIT_CONV_DONE  = 1;
    localparam int         IPS_BIT_TIMER3     = 0;
    localparam logic [7:0] IPS_PRIO_RESET     = 8'h00;
    localparam logic [7:0] IPS_PRIO_WMASK     = 8'hBF;

    // ==========================================================
    // status register fields
    localparam int         IPS_STAT_HIGH_CNT_LSB = 0;
    localparam int         IPS_STAT_RSVD_ERR     = 8;

endpackage

// [hdl/ips_prio_fanout.sv]
/*
 * splits the held priority byte into one level per interrupt source
 * and counts how many sources sit at high priority.
 * assumes its input comes from a register on the same clock.
 */
module ips_prio_fanout
    import ips_pkg::*;
(
    input  wire logic [7:0] prio_bits,
    output logic            clock_valid_prio,
    output logic            ext_irq7_prio,
    output logic            ext_irq6_prio,
    output logic            ext_irq5_prio,
    output logic            ext_irq4_prio,
    output logic            conv_done_prio,
    output logic            third_timer_prio,
    output logic [3:0]      high_count
);

    // ==========================================================
    // per-source levels: 0 low, 1 high
    // clock valid level
    assign clock_valid_prio = prio_bits[IPS_BIT_CLK_VALID];
    assign ext_irq7_prio    = prio_bits[IPS_BIT_EXT7];
    assign ext_irq6_prio    = prio_bits[IPS_BIT_EXT6];
    assign ext_irq5_prio    = prio_bits[IPS_BIT_EXT5];
    assign ext_irq4_prio    = prio_bits[IPS_BIT_EXT4];
    assign conv_done_prio   = prio_bits[IPS_BIT_CONV_DONE];
    assign third_timer_prio = prio_bits[IPS_BIT_TIMER3];

    // ==========================================================
    // population count of high-priority sources, reserved bit skipped
    always_comb begin
        high_count = 4'h0;
        for (int i = 0; i < IPS_PRIO_WIDTH; i++) begin
            if (i != IPS_BIT_RESERVED) begin
                high_count = high_count + {3'h0, prio_bits[i]};
            end
        end
    end

endmodule

// [hdl/ips_top.sv]
/*
 * interrupt priority select register with an ahb-lite slave port.
 * holds one priority bit per interrupt source and drives the levels to
 * the arbitration logic, plus a read-only status word with the number
 * of high-priority sources and a sticky flag for writes that set the
 * reserved bit.
 * assumes one clock and a single bus master issuing single word
 * transfers; all answers are zero wait state and always okay.
 * assumes the bus inputs come from logic on hclk, so none of them is
 * synchronised here; the levels change one cycle after the register.
 */
// Operation
// - clock valid interrupt: bit 0 means low, 1 means high priority
// - clock valid priority bit lives at bit 7
// - bit 6 reserved: software writes zero, reads always return zero
// - bit 5 selects ext irq 7 priority, 0 low 1 high
// - bit 4 selects ext irq 6 priority, 0 low 1 high
// - bit 3 selects ext irq 5 priority, 0 low 1 high
// - bit 2 selects ext irq 4 priority, 0 low 1 high
// - bit 1 selects converter end-of-conversion priority, 0 low 1 high
// - bit 0 holds timer 3 priority
module ips_top
    import ips_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             clock_valid_prio,
    output logic             ext_irq7_prio,
    output logic             ext_irq6_prio,
    output logic             ext_irq5_prio,
    output logic             ext_irq4_prio,
    output logic             conv_done_prio,
    output logic             third_timer_prio
);

    // ==========================================================
    // declarations
    logic [7:0]  prio_reg;
    logic        rsvd_err_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic        clk_valid_q, ext7_q, ext6_q, ext5_q, ext4_q, conv_q, tmr3_q;
    logic        clk_valid_w, ext7_w, ext6_w, ext5_w, ext4_w, conv_w, tmr3_w;
    logic [3:0]  high_count;
    logic        access;
    logic [31:0] rd_value;
    logic        hreadyout_reg;
    logic        hresp_reg;

    // decode of one register address, used for reads and writes
    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
        is_reg = (addr[7:2] == off[7:2]);
    endfunction

    // ==========================================================
    // elaboration checks: the byte-wide register, the fanout and the
    // status word are written for this layout and refuse any other
    if (IPS_PRIO_WIDTH != 8) begin : g_chk_width
        $error("priority register width must be eight");
    end
    // every field must sit inside the byte
    if (IPS_BIT_CLK_VALID >= IPS_PRIO_WIDTH || IPS_BIT_RESERVED >= IPS_PRIO_WIDTH) begin : g_chk_top_bits
        $error("clock valid or reserved field outside the register");
    end
    if (IPS_BIT_EXT7 >= IPS_PRIO_WIDTH || IPS_BIT_EXT6 >= IPS_PRIO_WIDTH) begin : g_chk_ext_hi
        $error("ext irq 7 or 6 field outside the register");
    end
    if (IPS_BIT_EXT5 >= IPS_PRIO_WIDTH || IPS_BIT_EXT4 >= IPS_PRIO_WIDTH) begin : g_chk_ext_lo
        $error("ext irq 5 or 4 field outside the register");
    end
    if (IPS_BIT_CONV_DONE >= IPS_PRIO_WIDTH || IPS_BIT_TIMER3 >= IPS_PRIO_WIDTH) begin : g_chk_low_bits
        $error("conversion or timer field outside the register");
    end
    // the write mask and reset value must keep the reserved bit clear,
    // otherwise a read could return it as one
    if (IPS_PRIO_WMASK[IPS_BIT_RESERVED] != 1'h0) begin : g_chk_wmask
        $error("write mask must clear the reserved bit");
    end
    // every other bit is a source and must stay writable
    if ($countones(IPS_PRIO_WMASK) != IPS_PRIO_WIDTH - 1) begin : g_chk_wmask_ones
        $error("write mask must keep all seven source bits");
    end
    if (IPS_PRIO_RESET[IPS_BIT_RESERVED] != 1'h0) begin : g_chk_reset
        $error("reset value must clear the reserved bit");
    end
    // both registers are whole aligned words at different addresses
    if (IPS_PRIO_OFFSET[1:0] != 2'h0 || IPS_STATUS_OFFSET[1:0] != 2'h0) begin : g_chk_align
        $error("register offsets must be word aligned");
    end
    if (IPS_PRIO_OFFSET[7:2] == IPS_STATUS_OFFSET[7:2]) begin : g_chk_overlap
        $error("priority and status registers share a word");
    end
    // the four-bit count sits below the flag in the 32-bit status word
    if (IPS_STAT_HIGH_CNT_LSB + 4 > IPS_STAT_RSVD_ERR || IPS_STAT_RSVD_ERR > 31) begin : g_chk_status
        $error("status fields overlap or leave the word");
    end

    // ==========================================================
    // address phase qualification; hsize is not decoded because only
    // whole-word transfers are served, and narrower ones act as words
    assign access = hsel && hready && (htrans == IPS_HTRANS_NONSEQ || htrans == IPS_HTRANS_SEQ);

    // write strobe for the data phase: the address phase is taken here
    // and the data arrives a cycle later, so the decision is remembered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'h0;
        end else begin
            wr_pend_reg <= access && hwrite;
        end
    end

    // address of that write, kept for the same reason; loading it on
    // every cycle is harmless because only wr_pend_reg qualifies it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_reg <= 8'h00;
        end else begin
            wr_addr_reg <= haddr;
        end
    end

    // ==========================================================
    // priority register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_reg <= IPS_PRIO_RESET;
        end else if (wr_pend_reg && is_reg(wr_addr_reg, IPS_PRIO_OFFSET)) begin
            prio_reg <= hwdata[7:0] & IPS_PRIO_WMASK;
        end
    end

    // sticky flag when software breaks the write-zero promise; read clears it
    // in its address phase, the same edge that loads hrdata, so the read
    // that clears the flag still returns it as one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsvd_err_reg <= 1'b0;
        end else if (wr_pend_reg && is_reg(wr_addr_reg, IPS_PRIO_OFFSET) && hwdata[IPS_BIT_RESERVED]) begin
            // set wins over a read clear in the same cycle
            rsvd_err_reg <= 1'b1;
        end else if (access && !hwrite && is_reg(haddr, IPS_STATUS_OFFSET)) begin
            rsvd_err_reg <= 1'b0;
        end
    end

    // ==========================================================
    // per-source split and high-priority count
    // the count feeds only the status word, never the levels
    ips_prio_fanout u_fanout (
        .prio_bits        (prio_reg),
        .clock_valid_prio (clk_valid_w),
        .ext_irq7_prio    (ext7_w),
        .ext_irq6_prio    (ext6_w),
        .ext_irq5_prio    (ext5_w),
        .ext_irq4_prio    (ext4_w),
        .conv_done_prio   (conv_w),
        .third_timer_prio (tmr3_w),
        .high_count       (high_count)
    );

    // ==========================================================
    // read mux; unmapped words read zero
    // decoded from the live address so the word is loaded at the
    // address phase edge and stands for the whole data phase
    always_comb begin
        rd_value = 32'h0000_0000;
        if (is_reg(haddr, IPS_PRIO_OFFSET)) begin
            rd_value[7:0] = prio_reg & IPS_PRIO_WMASK;
        end else if (is_reg(haddr, IPS_STATUS_OFFSET)) begin
            rd_value[IPS_STAT_HIGH_CNT_LSB +: 4] = high_count;
            rd_value[IPS_STAT_RSVD_ERR]          = rsvd_err_reg;
        end
    end

    // read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (access && !hwrite) begin
            hrdata_reg <= rd_value;
        end
    end

    // ==========================================================
    // registered priority outputs, one flip-flop per source, one cycle
    // behind the register; the extra cycle keeps the count and fanout
    // logic off the arbitration inputs and lets them leave from registers
    // clock valid level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_valid_q <= 1'h0;
        end else begin
            clk_valid_q <= clk_valid_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext7_q <= 1'h0;
        end else begin
            ext7_q <= ext7_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext6_q <= 1'h0;
        end else begin
            ext6_q <= ext6_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext5_q <= 1'h0;
        end else begin
            ext5_q <= ext5_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext4_q <= 1'h0;
        end else begin
            ext4_q <= ext4_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_q <= 1'h0;
        end else begin
            conv_q <= conv_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr3_q <= 1'h0;
        end else begin
            tmr3_q <= tmr3_w;
        end
    end

    // ==========================================================
    // bus response: zero wait state and always okay, held in flip-flops
    // so every slave output leaves from a register as well
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'h1;
        end else begin
            hreadyout_reg <= 1'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_reg <= IPS_HRESP_OKAY;
        end else begin
            hresp_reg <= IPS_HRESP_OKAY;
        end
    end

    // ==========================================================
    // output wiring
    assign clock_valid_prio = clk_valid_q;
    assign ext_irq7_prio    = ext7_q;
    assign ext_irq6_prio    = ext6_q;
    assign ext_irq5_prio    = ext5_q;
    assign ext_irq4_prio    = ext4_q;
    assign conv_done_prio   = conv_q;
    assign third_timer_prio = tmr3_q;
    assign hrdata           = hrdata_reg;
    assign hreadyout        = hreadyout_reg;
    assign hresp            = hresp_reg;

endmodule

// [verification/ips_top_checker.sv]
/* checker for the priority select block: bus writes against levels.
   assumes it is bound to ips_top and sees only its ports. */
module ips_top_checker
    import ips_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        clock_valid_prio,
    input wire logic        ext_irq7_prio,
    input wire logic        ext_irq6_prio,
    input wire logic        ext_irq5_prio,
    input wire logic        ext_irq4_prio,
    input wire logic        conv_done_prio,
    input wire logic        third_timer_prio
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_q;
    logic rd_q;
    // ==========================================================
    // data phase markers: pair hwdata and hrdata with their address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr == IPS_PRIO_OFFSET;
            rd_q <= hsel && hready && htrans[1] && !hwrite && haddr == IPS_PRIO_OFFSET;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // levels follow the written byte two edges after the data phase
    AST_CLK_VALID: assert property (wr_q |-> ##2 clock_valid_prio == $past(hwdata[7], 2))
        else $error("clock valid level wrong");
    AST_RSVD_READ: assert property (rd_q |-> !hrdata[6])
        else $error("reserved bit read as one");
    AST_EXT7: assert property (wr_q |=> ##1 ext_irq7_prio == $past(hwdata[5], 2))
        else $error("ext irq 7 level wrong");
    AST_EXT6: assert property (wr_q ##2 1'b1 |-> ext_irq6_prio == $past(hwdata[4], 2))
        else $error("ext irq 6 level wrong");
    AST_EXT5: assert property (wr_q |-> ##2 ext_irq5_prio == $past(hwdata[3], 2))
        else $error("ext irq 5 level wrong");
    AST_EXT4: assert property (wr_q |=> ##1 ext_irq4_prio == $past(hwdata[2], 2))
        else $error("ext irq 4 level wrong");
    AST_CONV: assert property (wr_q |-> ##2 conv_done_prio == $past(hwdata[1], 2))
        else $error("conversion level wrong");
    AST_TIMER3: assert property (wr_q ##2 1'b1 |-> third_timer_prio == $past(hwdata[0], 2))
        else $error("timer 3 level wrong");
    cover property (wr_q && hwdata[7]);
    cover property (rd_q);
    cover property ($rose(third_timer_prio));
endmodule

bind ips_top ips_top_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .clock_valid_prio(clock_valid_prio), .ext_irq7_prio(ext_irq7_prio), .ext_irq6_prio(ext_irq6_prio),
    .ext_irq5_prio(ext_irq5_prio), .ext_irq4_prio(ext_irq4_prio), .conv_done_prio(conv_done_prio),
    .third_timer_prio(third_timer_prio));

// [verification/ips_top_tb.sv]
/* self-checking bench for ips_top over ahb-lite single word transfers.
   assumes zero wait answers are not relied on: every wait is bounded. */
module ips_top_tb
    import ips_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    wire  [6:0]  prio;
    int          n_errors, tests_run;
    // ==========================================================
    // clock and design; hready loops back from the only slave
    always #50 hclk = ~hclk;
    ips_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .clock_valid_prio(prio[6]), .ext_irq7_prio(prio[5]),
        .ext_irq6_prio(prio[4]), .ext_irq5_prio(prio[3]), .ext_irq4_prio(prio[2]),
        .conv_done_prio(prio[1]), .third_timer_prio(prio[0]));
    // ==========================================================
    // report and helpers
    task automatic finish_test;
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait for hready high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            finish_test;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= IPS_HTRANS_NONSEQ;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
        chk({31'h0, hresp}, {31'h0, IPS_HRESP_OKAY});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    // levels lag the register by one cycle after the data phase edge
    task automatic lvl_chk(input logic [7:0] v);
        repeat (2) @(posedge hclk);
        chk({25'h0, prio}, {25'h0, v[7], v[5:0]});
    endtask
    // ==========================================================
    // scenarios
    task automatic t_walk;
        logic [7:0] v;
        for (int b = 0; b < 8; b++) begin
            if (b != 6) begin
                v = 8'h01 << b;
                wr(IPS_PRIO_OFFSET, {24'h0, v});
                lvl_chk(v);
                rd_chk(IPS_PRIO_OFFSET, {24'h0, v});
            end
        end
    endtask
    task automatic t_unmapped;
        wr(8'h08, 32'hFF);
        rd_chk(8'h08, 32'h0);
        rd_chk(IPS_PRIO_OFFSET, 32'h80);
    endtask
    // mid-run reset: register, status and levels fall back to reset values
    task automatic t_reset;
        wr(IPS_PRIO_OFFSET, 32'h3F);
        lvl_chk(8'h3F);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({25'h0, prio}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(IPS_PRIO_OFFSET, {24'h0, IPS_PRIO_RESET});
        rd_chk(IPS_STATUS_OFFSET, 32'h0);
    endtask
    // ones everywhere, then back to back clear and read
    task automatic t_reserved;
        wr(IPS_PRIO_OFFSET, 32'hFFFFFFFF);
        lvl_chk(8'hBF);
        rd_chk(IPS_PRIO_OFFSET, 32'hBF);
        rd_chk(IPS_STATUS_OFFSET, 32'h107);
        rd_chk(IPS_STATUS_OFFSET, 32'h007);
        wr(IPS_PRIO_OFFSET, 32'h0);
        rd_chk(IPS_PRIO_OFFSET, 32'h0);
        lvl_chk(8'h00);
    endtask
    // ==========================================================
    // main sequence: reset for 20 cycles, then the scenarios
    initial begin
        {hclk, hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = IPS_HSIZE_WORD;
        n_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(IPS_PRIO_OFFSET, {24'h0, IPS_PRIO_RESET});
        lvl_chk(8'h00);
        t_walk;
        t_unmapped;
        t_reserved;
        t_reset;
        finish_test;
    end
endmodule
